/* core/pwos_regs.vh */
// register offsets, field positions and reset values of the pwm output shaping block
`ifndef PWOS_REGS_VH
`define PWOS_REGS_VH
// register word indices (byte address is four times the index)
`define PWOS_IDX_SWT        16'h2061
`define PWOS_IDX_SEG        16'h2062
`define PWOS_IDX_GATE       16'h2063
`define PWOS_IDX_PD         16'h2064
`define PWOS_IDX_STAT       16'h2065
`define PWOS_IDX_RESTART    16'h2066
// output segment fields
`define PWOS_SEG_XA_BIT     8
`define PWOS_SEG_XB_BIT     7
`define PWOS_SEG_XC_BIT     6
`define PWOS_SEG_RST        9'h000
// gate chop fields
`define PWOS_GATE_HI_BIT    8
`define PWOS_GATE_LO_BIT    9
`define PWOS_GATE_RST       10'h000
// restart register bits: period, duty a, duty b, duty c
`define PWOS_RESTART_ALL    4'hf
// status fields
`define PWOS_STAT_TRIP_BIT  0
`define PWOS_STAT_SHUT_BIT  1
`define PWOS_STAT_HALF_BIT  3
`endif

/* core/pwos_top.v */
// pwm output shaping: pulse deletion, crossover, disables, gate chop, shutdown
//
// Contract
// R01 - minimum on-time equals count times clock
// R02 - short pulse off, complement fully on
// R03 - nine-bit readable writable segment register
// R04 - bits 8,7,6 cross pairs a,b,c
// R05 - crossover swaps high and low signals
// R06 - reset clears crossover bits
// R07 - bits 0-5 force outputs off
// R08 - disables gate after crossover swap
// R09 - reset clears all disable bits
// R10 - segment latched on sync rising edge
// R11 - gate bits 8/9 chop high/low outputs
// R12 - chop period four times divider plus one
// R13 - reset clears gate chop register
// R14 - software sets chop before running pwm
// R15 - trip low forces off, blocks sync
// R16 - trip level readable in status bit 0
// R17 - current sense falling edge also trips
// R18 - any write to flag shuts down
// R19 - flag read reports source, then clears
// R20 - fault clear needs trip and sense high
// R21 - rewrite period and duties to restart
// R22 - sync once or twice per period
// R23 - outputs off until restart writes complete
`timescale 1ns/1ps
`include "pwos_regs.vh"

module pwos_top #(
  parameter PD_W = 16                         // width of the minimum pulse count
) (
  // clock and reset
  input  wire        clk_sys_i,
  input  wire        resetn_i,
  // apb slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [31:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output wire        pready_o,
  output reg  [31:0] prdata_o,
  output wire        pslverr_o,
  // timing unit side
  input  wire [5:0]  tu_pwm_i,                // raw signals {ch,cl,bh,bl,ah,al}
  input  wire        tu_sync_i,               // raw period sync pulse
  input  wire        tu_half_i,               // active half: 0 first, 1 second
  input  wire        tu_double_i,             // 1 = double update mode
  output wire        period_sync_pulse_o,     // sync after trip gating
  // fault inputs, trip event and shutdown outputs
  input  wire        fault_trip_n_i,          // external trip, active low
  input  wire        bus_current_sense_ok_i,  // comparator high above threshold
  output wire        trip_event_o,            // one-cycle trip interrupt pulse
  output wire        shutdown_o,              // shutdown state, level
  // gate drive pins
  output wire        phase_a_high_out_o,
  output wire        phase_a_low_out_o,
  output wire        phase_b_high_out_o,
  output wire        phase_b_low_out_o,
  output wire        phase_c_high_out_o,
  output wire        phase_c_low_out_o
);

  // register state
  reg  [8:0]      seg_ctrl_q;         // software copy of output segment control
  reg  [8:0]      seg_live_q;         // copy in effect, latched on sync
  reg  [9:0]      gate_ctrl_q;        // gate chop control
  reg  [PD_W-1:0] min_pulse_count_q;  // minimum on-time in clocks
  reg             sw_flag_q;          // last shutdown came from software
  reg             shut_q;             // shutdown latched
  reg  [3:0]      restart_q;          // restart writes seen since shutdown
  reg             sync_d1_q;          // previous sync, for edge detect
  reg             sense_d1_q;         // previous sense level, for edge detect
  reg             trip_d1_q;          // previous trip level, for edge detect
  // pulse deletion state
  reg  [PD_W-1:0] on_cnt_q [0:5];     // on-time counters of this half
  reg  [5:0]      keep_q;             // signal allowed in current half
  reg  [5:0]      long_q;             // signal reached minimum in this half
  reg             half_q;             // half seen last cycle
  // chop carrier
  reg  [9:0]      chop_cnt_q;         // counts one carrier half period
  reg             chop_q;             // carrier level

  // apb decode
  wire        wr_en    = psel_i & penable_i & pwrite_i;
  wire        rd_en    = psel_i & penable_i & ~pwrite_i;
  wire [29:0] word_idx = paddr_i[31:2];
  wire        aligned  = (paddr_i[1:0] == 2'h0);

  // match a word index against a register index
  function hit;
    input [29:0] idx;
    input [15:0] reg_idx;
    begin
      hit = aligned & (idx == {14'h0000, reg_idx});
    end
  endfunction

  wire sel_swt  = hit(word_idx, `PWOS_IDX_SWT);
  wire sel_seg  = hit(word_idx, `PWOS_IDX_SEG);
  wire sel_gate = hit(word_idx, `PWOS_IDX_GATE);
  wire sel_pd   = hit(word_idx, `PWOS_IDX_PD);
  wire sel_stat = hit(word_idx, `PWOS_IDX_STAT);
  wire sel_rst  = hit(word_idx, `PWOS_IDX_RESTART);
  wire mapped   = sel_swt | sel_seg | sel_gate | sel_pd | sel_stat | sel_rst;

  // zero wait states; unmapped access answers with an error
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~mapped;

  // fault sources: trip pin level and sense comparator falling edge
  wire sense_fall = sense_d1_q & ~bus_current_sense_ok_i;             // R17
  wire trip_fall  = trip_d1_q & ~fault_trip_n_i;
  wire sw_shut    = wr_en & sel_swt;                                  // R18
  wire hw_fault   = ~fault_trip_n_i | sense_fall;
  wire fault_now  = hw_fault | sw_shut;
  // fault cleared only with trip high and sense above threshold
  wire fault_gone = fault_trip_n_i & bus_current_sense_ok_i;          // R20
  // the trip pin acts without the clock so the pins fall instantly
  wire off_all    = shut_q | ~fault_trip_n_i;                         // R15

  assign shutdown_o   = shut_q;
  assign trip_event_o = trip_fall | sense_fall | sw_shut;             // R15
  assign period_sync_pulse_o = tu_sync_i & ~off_all;                  // R15
  wire sync_rise = period_sync_pulse_o & ~sync_d1_q;                  // R10 R22

  // register writes and shutdown sequencing
  always @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      seg_ctrl_q        <= `PWOS_SEG_RST;                             // R06 R09
      seg_live_q        <= `PWOS_SEG_RST;
      gate_ctrl_q       <= `PWOS_GATE_RST;                            // R13
      min_pulse_count_q <= {PD_W{1'b0}};
      sw_flag_q         <= 1'b0;
      shut_q            <= 1'b0;
      restart_q         <= 4'h0;
      sync_d1_q         <= 1'b0;
      sense_d1_q        <= 1'b1;
      trip_d1_q         <= 1'b1;
    end
    else
    begin
      sync_d1_q  <= period_sync_pulse_o;
      sense_d1_q <= bus_current_sense_ok_i;
      trip_d1_q  <= fault_trip_n_i;
      if (wr_en && sel_seg)
      begin
        seg_ctrl_q <= pwdata_i[8:0];                                  // R03
      end
      if (wr_en && sel_gate)
      begin
        gate_ctrl_q <= pwdata_i[9:0];                                 // R11 R14
      end
      if (wr_en && sel_pd)
      begin
        min_pulse_count_q <= pwdata_i[PD_W-1:0];                      // R01
      end
      // new segment value only takes effect at sync rising edge
      if (sync_rise)
      begin
        seg_live_q <= seg_ctrl_q;                                     // R10
      end
      // source flag: set by software shutdown wins over the read clear
      if (sw_shut)
      begin
        sw_flag_q <= 1'b1;                                            // R19
      end
      else if (rd_en && sel_swt)
      begin
        sw_flag_q <= 1'b0;                                            // R19
      end
      else if (hw_fault)
      begin
        sw_flag_q <= 1'b0;
      end
      // shutdown holds until fault gone and all restart writes are seen
      if (fault_now)
      begin
        shut_q    <= 1'b1;                                            // R23
        restart_q <= 4'h0;
      end
      else if (shut_q)
      begin
        if (wr_en && sel_rst && fault_gone)
        begin
          restart_q <= restart_q | pwdata_i[3:0];                     // R21
        end
        if (restart_q == `PWOS_RESTART_ALL && fault_gone)
        begin
          shut_q    <= 1'b0;                                          // R20 R21 R23
          restart_q <= 4'h0;
        end
      end
    end
  end

  // apb read data, registered at the edge that ends the setup phase
  always @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      prdata_o <= 32'h0000_0000;
    end
    else if (psel_i && !penable_i && !pwrite_i)
    begin
      prdata_o <= 32'h0000_0000;
      if (sel_swt)
        prdata_o[0] <= sw_flag_q;                                     // R19
      if (sel_seg)
        prdata_o[8:0] <= seg_ctrl_q;                                  // R03
      if (sel_gate)
        prdata_o[9:0] <= gate_ctrl_q;
      if (sel_pd)
        prdata_o[PD_W-1:0] <= min_pulse_count_q;
      if (sel_stat)
      begin
        prdata_o[`PWOS_STAT_TRIP_BIT] <= fault_trip_n_i;              // R16
        prdata_o[`PWOS_STAT_SHUT_BIT] <= shut_q;
        prdata_o[`PWOS_STAT_HALF_BIT] <= tu_half_i;
      end
      if (sel_rst)
        prdata_o[3:0] <= restart_q;
    end
  end

  // pulse deletion: a signal is shown in a half only if its on-time in the
  // previous half was zero or reached the minimum; this costs one half of
  // latency but removes narrow pulses without look-ahead.
  wire half_edge = (tu_half_i != half_q);
  integer i;
  always @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      half_q <= 1'b0;
      keep_q <= 6'h3f;
      long_q <= 6'h00;
      for (i = 0; i < 6; i = i + 1)
        on_cnt_q[i] <= {PD_W{1'b0}};
    end
    else
    begin
      half_q <= tu_half_i;
      for (i = 0; i < 6; i = i + 1)
      begin
        if (half_edge)
        begin
          // the boundary cycle already belongs to the new half, so count it
          on_cnt_q[i] <= {{(PD_W-1){1'b0}}, tu_pwm_i[i]};
          long_q[i]   <= tu_pwm_i[i] & (min_pulse_count_q <= {{(PD_W-1){1'b0}}, 1'b1}); // R01
          // zero on-time is not a pulse to delete
          keep_q[i]   <= long_q[i] | (on_cnt_q[i] == {PD_W{1'b0}}); // R01 R02
        end
        else if (tu_pwm_i[i])
        begin
          if (on_cnt_q[i] != {PD_W{1'b1}})
            on_cnt_q[i] <= on_cnt_q[i] + {{(PD_W-1){1'b0}}, 1'b1};
          if ((on_cnt_q[i] + {{(PD_W-1){1'b0}}, 1'b1}) >= min_pulse_count_q)
            long_q[i] <= 1'b1;                                        // R01
        end
      end
    end
  end

  // deleted signal goes off, its complement (index xor 1) fully on
  reg [5:0] shaped;
  integer k;
  always @*
  begin
    shaped = 6'h00;
    for (k = 0; k < 6; k = k + 1)
    begin
      if (!keep_q[k])
        shaped[k] = 1'b0;                                             // R02
      else if (!keep_q[k ^ 1])
        shaped[k] = 1'b1;                                             // R02
      else
        shaped[k] = tu_pwm_i[k];
    end
  end

  // crossover swap then per-output disable
  wire xa = seg_live_q[`PWOS_SEG_XA_BIT];                             // R04
  wire xb = seg_live_q[`PWOS_SEG_XB_BIT];                             // R04
  wire xc = seg_live_q[`PWOS_SEG_XC_BIT];                             // R04
  wire [5:0] crossed = {xc ? shaped[4] : shaped[5], xc ? shaped[5] : shaped[4],
                        xb ? shaped[2] : shaped[3], xb ? shaped[3] : shaped[2],
                        xa ? shaped[0] : shaped[1], xa ? shaped[1] : shaped[0]}; // R05
  // disable bits run from phase c high (bit 0) up to phase a low (bit 5)
  wire [5:0] dis_pin = {seg_live_q[0], seg_live_q[1], seg_live_q[2],
                        seg_live_q[3], seg_live_q[4], seg_live_q[5]};  // R07
  wire [5:0] enabled = crossed & ~dis_pin;                            // R07 R08

  // chop carrier: half period is 2*(divider+1) clocks
  wire [9:0] chop_half = {1'b0, gate_ctrl_q[7:0], 1'b0} + 10'h002;
  always @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      chop_cnt_q <= 10'h000;
      chop_q     <= 1'b0;
    end
    else if (chop_cnt_q + 10'h001 >= chop_half)
    begin
      chop_cnt_q <= 10'h000;
      chop_q     <= ~chop_q;                                          // R12
    end
    else
    begin
      chop_cnt_q <= chop_cnt_q + 10'h001;
    end
  end

  wire chop_hi = ~gate_ctrl_q[`PWOS_GATE_HI_BIT] | chop_q;            // R11
  wire chop_lo = ~gate_ctrl_q[`PWOS_GATE_LO_BIT] | chop_q;            // R11
  wire [5:0] chopped = enabled & {chop_hi, chop_lo, chop_hi, chop_lo, chop_hi, chop_lo};
  wire [5:0] pins    = off_all ? 6'h00 : chopped;                     // R15 R23

  assign phase_a_low_out_o  = pins[0];
  assign phase_a_high_out_o = pins[1];
  assign phase_b_low_out_o  = pins[2];
  assign phase_b_high_out_o = pins[3];
  assign phase_c_low_out_o  = pins[4];
  assign phase_c_high_out_o = pins[5];

endmodule // pwos_top

/* sim/pwos_top_properties.sv */
// port-level checks of the output shaping block
`timescale 1ns/1ps
module pwos_top_properties (
  // clock, reset and bus
  input wire logic        clk_sys_i, resetn_i, psel_i, penable_i, pwrite_i,
  input wire logic [31:0] paddr_i,
  // sync and faults
  input wire logic        tu_sync_i, period_sync_pulse_o, fault_trip_n_i,
  input wire logic        bus_current_sense_ok_i, trip_event_o, shutdown_o,
  // gate pins
  input wire logic        phase_a_high_out_o, phase_a_low_out_o, phase_b_high_out_o,
  input wire logic        phase_b_low_out_o, phase_c_high_out_o, phase_c_low_out_o
);
  wire [5:0] pins   = {phase_c_high_out_o, phase_c_low_out_o, phase_b_high_out_o,
                       phase_b_low_out_o, phase_a_high_out_o, phase_a_low_out_o};
  wire       wr_acc = psel_i & penable_i & pwrite_i; // completed write
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  a_trip_pins_off: assert property (!fault_trip_n_i |-> pins == 6'h00) else $error("pin on in trip");
  a_shut_pins_off: assert property (shutdown_o |-> pins == 6'h00) else $error("pin on in shutdown");
  a_sync_blocked: assert property (!fault_trip_n_i || shutdown_o |-> !period_sync_pulse_o) else $error("sync leak");
  a_sync_passed: assert property (fault_trip_n_i && !shutdown_o |-> period_sync_pulse_o == tu_sync_i) else $error("sync lost");
  a_trip_irq: assert property ($fell(fault_trip_n_i) |-> trip_event_o) else $error("no trip event");
  a_trip_latch: assert property ($fell(fault_trip_n_i) |=> shutdown_o) else $error("trip not held");
  a_sense_trip: assert property ($fell(bus_current_sense_ok_i) |=> shutdown_o) else $error("sense no trip");
  a_sw_shut: assert property (wr_acc && paddr_i == 32'h0000_8184 |=> shutdown_o) else $error("sw no trip");
  a_shut_hold: assert property (shutdown_o && !wr_acc && !$past(wr_acc) |=> shutdown_o) else $error("left shutdown");
  a_fault_hold: assert property (shutdown_o && !bus_current_sense_ok_i |=> shutdown_o) else $error("early restart");
  // main scenarios seen
  c_trip: cover property ($fell(fault_trip_n_i));
  c_restart: cover property ($fell(shutdown_o));
  c_sync: cover property ($rose(period_sync_pulse_o));
endmodule // pwos_top_properties

/* sim/pwos_fault_model.sv */
// far side: fault sensing on the inverter that feeds trip pin and comparator
`timescale 1ns/1ps
module pwos_fault_model (
  input  wire logic clk_i,
  input  wire logic trip_req_i,   // bench asks for an external fault
  input  wire logic sense_low_i,  // bench asks for bus overcurrent
  output logic      fault_trip_n_o,
  output logic      sense_ok_o
);
  initial fault_trip_n_o = 1'b1;
  initial sense_ok_o = 1'b1;
  // levels move only after an edge; each output follows its own request one clock late
  always @(posedge clk_i)
  begin
    fault_trip_n_o <= !trip_req_i;
    sense_ok_o     <= !sense_low_i;
  end
endmodule // pwos_fault_model

/* sim/test_pwm_output_shaping_and_shutdown.sv */
// self-checking bench of the pwm output shaping block
`timescale 1ns/1ps
`include "pwos_regs.vh"
module test_pwm_output_shaping_and_shutdown;
  logic        clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, sync = 0, half = 0;
  logic        trip_req = 0, sense_low = 0, perr_seen;
  logic [31:0] paddr = 0, pwd = 0;
  logic [5:0]  pwm = 0;           // raw {ch,cl,bh,bl,ah,al}
  wire  [31:0] prd;
  wire  [5:0]  pins;              // same order as pwm
  wire         prdy, perr, psync, shut, trip_n, sense_ok;
  int          n_fail = 0, checks_done = 0;
  pwos_top i_dut (.clk_sys_i(clk), .resetn_i(rstn), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwd), .pready_o(prdy), .prdata_o(prd), .pslverr_o(perr), .tu_pwm_i(pwm),
    .tu_sync_i(sync), .tu_half_i(half), .tu_double_i(1'b0), .period_sync_pulse_o(psync),
    .fault_trip_n_i(trip_n), .bus_current_sense_ok_i(sense_ok), .trip_event_o(), .shutdown_o(shut),
    .phase_a_high_out_o(pins[1]), .phase_a_low_out_o(pins[0]), .phase_b_high_out_o(pins[3]),
    .phase_b_low_out_o(pins[2]), .phase_c_high_out_o(pins[5]), .phase_c_low_out_o(pins[4]));
  pwos_fault_model i_far (.clk_i(clk), .trip_req_i(trip_req), .sense_low_i(sense_low),
    .fault_trip_n_o(trip_n), .sense_ok_o(sense_ok));
  initial forever #2.5 clk = !clk;
  task chk(input [31:0] s, input [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // one apb transfer; held until pready is seen high at an edge
  task apb(input bit w, input [15:0] idx, input [31:0] d, output [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    {psel, pen, pwr, paddr, pwd} <= {1'b1, 1'b0, w, 14'h0, idx, 2'b00, d};
    @(posedge clk) pen <= 1;
    do @(posedge clk); while (prdy !== 1'b1 && ++n < 50);
    r = prd;
    perr_seen = perr;
    psel <= 0;
    pen <= 0;
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task pulse_sync;
    @(posedge clk) sync <= 1;
    @(posedge clk) sync <= 0;
    tick(2);
  endtask
  task t_regs;
    logic [31:0] r;
    apb(0, `PWOS_IDX_SEG, 0, r); chk(r, 0);
    apb(0, `PWOS_IDX_GATE, 0, r); chk(r, 0);
    apb(1, `PWOS_IDX_SEG, 32'hffff_ffff, r);
    apb(0, `PWOS_IDX_SEG, 0, r); chk(r, 32'h1ff);
    apb(1, `PWOS_IDX_SEG, 0, r);
    apb(0, `PWOS_IDX_STAT, 0, r); chk(r[0], 1);
    apb(0, 16'h2070, 0, r); chk(perr_seen, 1);
  endtask
  // each pair crossed alone, only after the sync edge
  task t_cross;
    logic [31:0] r;
    for (int p = 0; p < 3; p++)
    begin
      apb(1, `PWOS_IDX_SEG, 32'h100 >> p, r);
      @(posedge clk) pwm <= 6'h02 << (2 * p);
      tick(1); chk(pins, 6'h02 << (2 * p));
      pulse_sync; chk(pins, 6'h01 << (2 * p));
    end
    // cross b with four outputs disabled: disables act on the swapped pins
    apb(1, `PWOS_IDX_SEG, 32'h0a7, r);
    @(posedge clk) pwm <= 6'h3b;
    pulse_sync; chk(pins, 6'h06);
    apb(1, `PWOS_IDX_SEG, 32'h03f, r);
    pulse_sync; chk(pins, 6'h00);
    apb(1, `PWOS_IDX_SEG, 0, r);
    pulse_sync;
  endtask
  // chop set while phase a high and low are driven on, then counted over two carrier periods
  task t_chop;
    logic [31:0] r;
    int h, l;
    @(posedge clk) pwm <= 6'h03;
    for (int k = 0; k < 2; k++)
    begin
      apb(1, `PWOS_IDX_GATE, k ? 32'h201 : 32'h100, r);
      tick(2);
      h = 0;
      l = 0;
      repeat (8 * (k + 1))
      begin
        tick(1);
        h += pins[1];
        l += pins[0];
      end
      chk(h, k ? 16 : 4);
      chk(l, 8);
    end
    apb(1, `PWOS_IDX_GATE, 0, r);
  endtask
  // three halves of 20 clocks with a 3-clock high pulse; threshold 4 deletes, 3 keeps
  task t_pd;
    logic [31:0] r;
    int h, l;
    for (int pd = 4; pd > 2; pd--)
    begin
      apb(1, `PWOS_IDX_PD, pd, r);
      repeat (3)
      begin
        h = 0;
        l = 0;
        for (int i = 0; i < 20; i++)
        begin
          @(posedge clk);
          pwm <= (i < 3) ? 6'h02 : 6'h01;
          if (i == 0) half <= !half;
          #1;
          h += pins[1];
          l += pins[0];
        end
      end
      chk(h, pd == 4 ? 0 : 3);
      chk(l, pd == 4 ? 20 : 17);
    end
    apb(1, `PWOS_IDX_PD, 0, r);
  endtask
  task t_trip;
    logic [31:0] r;
    @(posedge clk) pwm <= 6'h15;
    trip_req <= 1;
    sync <= 1;
    tick(2); chk(pins, 0); chk(psync, 0);
    apb(0, `PWOS_IDX_STAT, 0, r); chk(r[0], 0);
    @(posedge clk) trip_req <= 0;
    sync <= 0;
    sense_low <= 1;
    tick(4); chk(pins, 0);
    apb(1, `PWOS_IDX_RESTART, 32'hf, r);
    tick(2); chk(shut, 1);
    @(posedge clk) sense_low <= 0;
    apb(0, `PWOS_IDX_SWT, 0, r); chk(r[0], 0);
    apb(1, `PWOS_IDX_RESTART, 32'hf, r);
    tick(2); chk(pins, 6'h15);
    apb(1, `PWOS_IDX_SWT, 1, r);
    tick(1); chk(shut, 1);
    apb(0, `PWOS_IDX_SWT, 0, r); chk(r[0], 1);
    apb(0, `PWOS_IDX_SWT, 0, r); chk(r[0], 0);
    apb(1, `PWOS_IDX_RESTART, 32'hf, r);
    tick(2); chk(shut, 0);
  endtask
  task end_of_test;
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rstn <= 1;
    t_regs;
    t_cross;
    t_chop;
    t_pd;
    t_trip;
    end_of_test;
  end
  // the run needs about 300 clocks; cut a hang well beyond that
  initial
  begin
    #100000;
    n_fail++;
    end_of_test;
  end
endmodule // test_pwm_output_shaping_and_shutdown
bind pwos_top pwos_top_properties u_chk (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .tu_sync_i(tu_sync_i),
  .period_sync_pulse_o(period_sync_pulse_o), .fault_trip_n_i(fault_trip_n_i),
  .bus_current_sense_ok_i(bus_current_sense_ok_i), .trip_event_o(trip_event_o), .shutdown_o(shutdown_o),
  .phase_a_high_out_o(phase_a_high_out_o), .phase_a_low_out_o(phase_a_low_out_o),
  .phase_b_high_out_o(phase_b_high_out_o), .phase_b_low_out_o(phase_b_low_out_o),
  .phase_c_high_out_o(phase_c_high_out_o), .phase_c_low_out_o(phase_c_low_out_o));
